// ---- inc/err_report_defs.svh ----
// timing and field constants for the error report port
`ifndef ERR_REPORT_DEFS_SVH
`define ERR_REPORT_DEFS_SVH
`define HDR_W 48
`define HDR_LADDR_HI 47
`define HDR_LADDR_LO 41
`define HDR_BCNT_HI 40
`define HDR_BCNT_LO 29
`define HDR_TC_HI 28
`define HDR_TC_LO 26
`define HDR_ATTR_HI 25
`define HDR_ATTR_LO 24
`define HDR_RID_HI 23
`define HDR_RID_LO 8
`define HDR_TAG_HI 7
`define HDR_TAG_LO 0
`define CPL_BUSY_CYCLES 4'h4
`define STAT_UR 3'h1
`define STAT_CA 3'h4
`endif

// ---- inc/err_report_pkg.sv ----
// shared types for the error report port
package err_report_pkg;
	typedef enum logic [1:0] {
		CPL_IDLE = 2'b00,
		CPL_SEND = 2'b01,
		CPL_WAIT = 2'b11
	} cpl_state_e;
	typedef struct packed {
		logic [6:0] lower_addr;
		logic [11:0] byte_count;
		logic [2:0] tc;
		logic [1:0] attr;
		logic [15:0] requester_id;
		logic [7:0] tag;
	} cpl_hdr_s;
	typedef logic [2:0] cpl_status_t;
endpackage : err_report_pkg

// ---- inc/err_report_if.sv ----
// signals between user logic and the core's error report port
`timescale 1ns/1ps
interface err_report_if (input wire logic REF_CLK);
	logic ecrc_err_l;
	logic report_unsupported_req_l;
	logic cpl_timeout_l;
	logic cpl_unexpected_l;
	logic cpl_abort_l;
	logic posted_l;
	logic locked_l;
	logic correctable_l;
	logic [47:0] cpl_header;
	logic cpl_ready_l;
	modport core (
		input ecrc_err_l, report_unsupported_req_l, cpl_timeout_l, cpl_unexpected_l,
		input cpl_abort_l, posted_l, locked_l, correctable_l, cpl_header,
		output cpl_ready_l
	);
	modport user (
		output ecrc_err_l, report_unsupported_req_l, cpl_timeout_l, cpl_unexpected_l,
		output cpl_abort_l, posted_l, locked_l, correctable_l, cpl_header,
		input cpl_ready_l
	);
endinterface : err_report_if

// ---- core/err_report_core.sv ----
// core end: accepts error reports and builds error completions
// Operation
// RULE_01 - user reports end-to-end CRC error low
// RULE_02 - user reports unsupported request low
// RULE_03 - core ignores UR/abort while not ready
// RULE_04 - core drives ready low when accepting
// RULE_05 - user pulses abort low while ready; posted aborts are pulsed here without waiting for ready
// RULE_06 - user reports completion timeout low
// RULE_07 - user reports unexpected completion low
// RULE_08 - user reports correctable error low
// RULE_09 - posted qualifier marks faulting transaction posted
// RULE_10 - locked qualifier marks faulting transaction locked
// RULE_11 - user supplies 48-bit header with report
// RULE_12 - core builds completion from header fields
// RULE_13 - legacy locked UR/abort gives locked completion
// RULE_14 - non-legacy core decides locked completion itself
// RULE_15 - timeout/correctable only in D0
// RULE_16 - one-cycle reports, qualifiers same cycle
`timescale 1ns/1ps
`include "err_report_defs.svh"
module err_report_core #(
	parameter int BUSY_CYCLES = `CPL_BUSY_CYCLES
) (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	err_report_if.core LINK,
	input wire logic LEGACY_MODE,
	input wire logic REQ_WAS_LOCKED,
	input wire logic CPL_TAKEN,
	output logic CPL_VALID,
	output logic CPL_LOCKED,
	output logic [2:0] CPL_STATUS,
	output logic [47:0] CPL_HEADER,
	output logic EV_ECRC,
	output logic EV_UR,
	output logic EV_CA,
	output logic EV_TIMEOUT,
	output logic EV_UNEXPECTED,
	output logic EV_CORRECTABLE,
	output logic EV_POSTED,
	output logic EV_LOCKED
);
	if (BUSY_CYCLES < 1 || BUSY_CYCLES > 15)
	begin : g_busy_range
		$error("BUSY_CYCLES out of range");
	end

	typedef struct packed {
		err_report_pkg::cpl_state_e st;
		logic [3:0] busy;
		logic cpl_locked;
		err_report_pkg::cpl_status_t status;
		err_report_pkg::cpl_hdr_s hdr;
		logic [7:0] ev;
	} state_s;

	state_s cur;
	state_s next_cur;
	logic ready;
	logic take_ur;
	logic take_ca;
	logic any_rep;

	assign ready = (cur.st == err_report_pkg::CPL_IDLE);
	assign LINK.cpl_ready_l = ~ready; // RULE_04
	// gate UR/abort on ready; posted reports need no completion
	assign take_ur = ready && !LINK.report_unsupported_req_l; // RULE_03 RULE_02
	assign take_ca = ready && !LINK.cpl_abort_l; // RULE_03 RULE_05
	assign any_rep = !LINK.ecrc_err_l || take_ur || take_ca || !LINK.cpl_timeout_l
		|| !LINK.cpl_unexpected_l || !LINK.correctable_l; // RULE_16

	always_comb
	begin
		next_cur = cur;
		next_cur.ev = '0;
		next_cur.ev[0] = !LINK.ecrc_err_l; // RULE_01
		next_cur.ev[1] = take_ur;
		next_cur.ev[2] = take_ca;
		next_cur.ev[3] = !LINK.cpl_timeout_l; // RULE_06 RULE_15
		next_cur.ev[4] = !LINK.cpl_unexpected_l; // RULE_07
		next_cur.ev[5] = !LINK.correctable_l; // RULE_08
		next_cur.ev[6] = any_rep && !LINK.posted_l; // RULE_09
		next_cur.ev[7] = any_rep && !LINK.locked_l; // RULE_10
		case (cur.st)
			err_report_pkg::CPL_IDLE:
			begin
				if ((take_ur || take_ca) && LINK.posted_l) // RULE_09
				begin
					next_cur.st = err_report_pkg::CPL_SEND;
					next_cur.hdr = LINK.cpl_header; // RULE_11 RULE_12
					next_cur.status = take_ur ? `STAT_UR : `STAT_CA;
					next_cur.cpl_locked = LEGACY_MODE ? !LINK.locked_l
						: REQ_WAS_LOCKED; // RULE_13 RULE_14
				end
			end
			err_report_pkg::CPL_SEND:
			begin
				if (CPL_TAKEN)
				begin
					next_cur.st = err_report_pkg::CPL_WAIT;
					next_cur.busy = 4'(BUSY_CYCLES);
				end
			end
			err_report_pkg::CPL_WAIT:
			begin
				// short hold-off lets the completion leave before the next one
				next_cur.busy = cur.busy - 4'h1;
				if (cur.busy == 4'h1)
					next_cur.st = err_report_pkg::CPL_IDLE;
			end
			default:
				next_cur.st = err_report_pkg::CPL_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign CPL_VALID = (cur.st == err_report_pkg::CPL_SEND);
	assign CPL_LOCKED = cur.cpl_locked;
	assign CPL_STATUS = cur.status;
	assign CPL_HEADER = cur.hdr; // RULE_12
	assign EV_ECRC = cur.ev[0];
	assign EV_UR = cur.ev[1];
	assign EV_CA = cur.ev[2];
	assign EV_TIMEOUT = cur.ev[3];
	assign EV_UNEXPECTED = cur.ev[4];
	assign EV_CORRECTABLE = cur.ev[5];
	assign EV_POSTED = cur.ev[6];
	assign EV_LOCKED = cur.ev[7];
endmodule : err_report_core

// ---- core/err_report_user.sv ----
// user end: turns detected errors into one-cycle active-low reports
`timescale 1ns/1ps
`include "err_report_defs.svh"
module err_report_user (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	err_report_if.user LINK,
	input wire logic DEV_IN_D0,
	input wire logic REQ_ECRC,
	input wire logic REQ_UR,
	input wire logic REQ_CA,
	input wire logic REQ_TIMEOUT,
	input wire logic REQ_UNEXPECTED,
	input wire logic REQ_CORRECTABLE,
	input wire logic REQ_POSTED,
	input wire logic REQ_LOCKED,
	input wire logic [47:0] REQ_HEADER,
	output logic REQ_ACCEPT,
	output logic DROPPED
);
	typedef struct packed {
		logic [7:0] drive_l;
		logic [47:0] hdr;
		logic dropped;
	} state_s;

	state_s cur;
	state_s next_cur;
	logic nonposted_ok;
	logic d0_ok;
	logic np_in_flight;
	logic any_req;

	// ready still reads low in the cycle our strobe is on the link, so count that strobe
	assign np_in_flight = (!cur.drive_l[1] || !cur.drive_l[2]) && cur.drive_l[6];
	// UR/abort for non-posted requests wait on ready; posted ones need no completion
	assign nonposted_ok = REQ_POSTED || (!LINK.cpl_ready_l && !np_in_flight); // RULE_05
	assign d0_ok = DEV_IN_D0; // RULE_15
	// qualifiers only ride along with a report that is really sent
	assign any_req = REQ_ECRC || REQ_UR || REQ_CA || REQ_UNEXPECTED
		|| ((REQ_TIMEOUT || REQ_CORRECTABLE) && d0_ok);
	assign REQ_ACCEPT = !((REQ_UR || REQ_CA) && !nonposted_ok);

	always_comb
	begin
		next_cur = cur;
		next_cur.drive_l = 8'hff; // RULE_16
		next_cur.dropped = 1'b0;
		if (REQ_ACCEPT)
		begin
			next_cur.drive_l[0] = !REQ_ECRC; // RULE_01
			next_cur.drive_l[1] = !REQ_UR; // RULE_02
			next_cur.drive_l[2] = !REQ_CA; // RULE_05
			next_cur.drive_l[3] = !(REQ_TIMEOUT && d0_ok); // RULE_06 RULE_15
			next_cur.drive_l[4] = !REQ_UNEXPECTED; // RULE_07
			next_cur.drive_l[5] = !(REQ_CORRECTABLE && d0_ok); // RULE_08 RULE_15
			next_cur.drive_l[6] = !(REQ_POSTED && any_req); // RULE_09
			next_cur.drive_l[7] = !(REQ_LOCKED && any_req); // RULE_10
			next_cur.hdr = REQ_HEADER; // RULE_11
			next_cur.dropped = !d0_ok && (REQ_TIMEOUT || REQ_CORRECTABLE);
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			cur.drive_l <= 8'hff;
			cur.hdr <= 48'h0000_0000_0000;
			cur.dropped <= 1'b0;
		end
		else
			cur <= next_cur;
	end

	assign LINK.ecrc_err_l = cur.drive_l[0];
	assign LINK.report_unsupported_req_l = cur.drive_l[1];
	assign LINK.cpl_abort_l = cur.drive_l[2];
	assign LINK.cpl_timeout_l = cur.drive_l[3];
	assign LINK.cpl_unexpected_l = cur.drive_l[4];
	assign LINK.correctable_l = cur.drive_l[5];
	assign LINK.posted_l = cur.drive_l[6];
	assign LINK.locked_l = cur.drive_l[7];
	assign LINK.cpl_header = cur.hdr;
	assign DROPPED = cur.dropped;
endmodule : err_report_user

// ---- sim/err_report_assertions.sv ----
// link checks between the user end and the core end
`timescale 1ns/1ps
module err_report_assertions (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic ecrc_err_l,
	input wire logic report_unsupported_req_l,
	input wire logic cpl_timeout_l,
	input wire logic cpl_unexpected_l,
	input wire logic cpl_abort_l,
	input wire logic posted_l,
	input wire logic locked_l,
	input wire logic correctable_l,
	input wire logic cpl_ready_l
);
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (SYS_RST);
	// posted reports never take the completion slot
	wire np_req = posted_l & ~(report_unsupported_req_l & cpl_abort_l);
	wire any_rep = ~&{ecrc_err_l, report_unsupported_req_l, cpl_timeout_l,
		cpl_unexpected_l, cpl_abort_l, correctable_l};
	ca_pulse_a: assert property (!cpl_abort_l && posted_l |=> cpl_abort_l || !posted_l)
		else $error("abort strobe held too long");
	ur_pulse_a: assert property (np_req && !report_unsupported_req_l |=> report_unsupported_req_l)
		else $error("unsupported strobe held too long");
	slot_free_a: assert property (np_req |-> !cpl_ready_l)
		else $error("report sent while core busy");
	slot_taken_a: assert property (np_req |=> cpl_ready_l)
		else $error("core did not take completion slot");
	busy_hold_a: assert property ($rose(cpl_ready_l) |-> cpl_ready_l [*5])
		else $error("ready returned too early");
	busy_cause_a: assert property ($rose(cpl_ready_l) |-> $past(np_req))
		else $error("busy without a report");
	posted_qual_a: assert property (!posted_l |-> any_rep)
		else $error("posted qualifier alone");
	locked_qual_a: assert property (!locked_l |-> any_rep)
		else $error("locked qualifier alone");
	cover property (np_req);
	cover property (!posted_l && any_rep);
	cover property (!locked_l && np_req);
endmodule : err_report_assertions

// ---- sim/pcie_error_report_port_tb.sv ----
// self-checking bench joining the user end to the core end
`timescale 1ns/1ps
module pcie_error_report_port_tb;
	logic clk = 0;
	logic rst = 1;
	logic legacy = 0, was_lk = 0, taken = 0, in_d0 = 1, posted = 0, locked = 0;
	logic [5:0] req = 6'h00;
	logic [47:0] hdr = 48'h0000_0000_0000;
	logic [5:0] ev;
	logic ev_p, ev_l, cvalid, clk_d, accept, dropped;
	logic [2:0] cstat;
	logic [47:0] chdr;
	int n_errors = 0;
	int num_checks = 0;
	int seed = 37;
	always #5 clk = ~clk;
	err_report_if link_if (.REF_CLK(clk));
	err_report_core err_report_core_inst (.REF_CLK(clk), .SYS_RST(rst), .LINK(link_if.core),
		.LEGACY_MODE(legacy), .REQ_WAS_LOCKED(was_lk), .CPL_TAKEN(taken), .CPL_VALID(cvalid),
		.CPL_LOCKED(clk_d), .CPL_STATUS(cstat), .CPL_HEADER(chdr), .EV_ECRC(ev[0]),
		.EV_UR(ev[1]), .EV_CA(ev[2]), .EV_TIMEOUT(ev[3]), .EV_UNEXPECTED(ev[4]),
		.EV_CORRECTABLE(ev[5]), .EV_POSTED(ev_p), .EV_LOCKED(ev_l));
	err_report_user err_report_user_inst (.REF_CLK(clk), .SYS_RST(rst), .LINK(link_if.user),
		.DEV_IN_D0(in_d0), .REQ_ECRC(req[0]), .REQ_UR(req[1]), .REQ_CA(req[2]),
		.REQ_TIMEOUT(req[3]), .REQ_UNEXPECTED(req[4]), .REQ_CORRECTABLE(req[5]),
		.REQ_POSTED(posted), .REQ_LOCKED(locked), .REQ_HEADER(hdr), .REQ_ACCEPT(accept),
		.DROPPED(dropped));
	err_report_assertions err_report_assertions_inst (.REF_CLK(clk), .SYS_RST(rst),
		.ecrc_err_l(link_if.ecrc_err_l), .report_unsupported_req_l(link_if.report_unsupported_req_l),
		.cpl_timeout_l(link_if.cpl_timeout_l), .cpl_unexpected_l(link_if.cpl_unexpected_l),
		.cpl_abort_l(link_if.cpl_abort_l), .posted_l(link_if.posted_l),
		.locked_l(link_if.locked_l), .correctable_l(link_if.correctable_l),
		.cpl_ready_l(link_if.cpl_ready_l));
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task give_verdict;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict
	// one report through both ends; refused kinds outside D0 must vanish
	task automatic send(input int k, input logic p, input logic lk);
		logic drop;
		drop = (k == 3 || k == 5) && !in_d0;
		req[k] = 1'b1;
		posted = p;
		locked = lk;
		hdr = 48'({$random(seed), $random(seed)});
		@(posedge clk);
		#1 req = 6'h00;
		posted = 1'b0;
		locked = 1'b0;
		chk(dropped, drop);
		@(posedge clk);
		#1 chk({ev, ev_p, ev_l}, drop ? 8'h00 : {6'h01 << k, p, lk});
		chk(cvalid, (k == 1 || k == 2) && !p);
		if ((k == 1 || k == 2) && !p)
		begin
			chk({cvalid, clk_d, cstat}, {1'b1, legacy ? lk : was_lk, k == 1 ? 3'h1 : 3'h4});
			chk(chdr, hdr);
			req[1] = 1'b1;
			#1 chk(accept, 1'b0);
			req[1] = 1'b0;
			taken = 1'b1;
			@(posedge clk);
			#1 taken = 1'b0;
			repeat (3) @(posedge clk);
			#1 chk(link_if.cpl_ready_l, 1'b1);
			@(posedge clk);
			#1 chk(link_if.cpl_ready_l, 1'b0);
		end
		posted = 1'b0;
		locked = 1'b0;
	endtask : send
	initial
	begin
		repeat (12) @(posedge clk);
		#1 rst = 1'b0;
		chk(link_if.cpl_ready_l, 1'b0);
		legacy = 1'b1;
		for (int k = 0; k < 6; k++)
			send(k, 1'b0, 1'b1);
		repeat (60)
		begin
			legacy = $random(seed);
			was_lk = $random(seed);
			in_d0 = ($random(seed) % 4) != 0;
			send($unsigned($random(seed)) % 6, $random(seed), $random(seed));
		end
		give_verdict();
	end
	initial
	begin
		#100000;
		n_errors++;
		give_verdict();
	end
endmodule : pcie_error_report_port_tb
